// >>> src/timer16_pkg.sv
package timer16_pkg;
	// ==================================================
	// register indices on the byte-wide cpu port
	localparam logic [3:0] ADDR_ACTION_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MODE_CTRL = 4'h1;
	localparam logic [3:0] ADDR_COUNT_LO = 4'h2;
	localparam logic [3:0] ADDR_COUNT_HI = 4'h3;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
	localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
	localparam logic [3:0] ADDR_CMPB_LO = 4'h6;
	localparam logic [3:0] ADDR_CMPB_HI = 4'h7;
	localparam logic [3:0] ADDR_CAPT_LO = 4'h8;
	localparam logic [3:0] ADDR_CAPT_HI = 4'h9;
	// ==================================================
	// field positions
	localparam int ACTION_A_POS = 6;
	localparam int ACTION_B_POS = 4;
	localparam int WAVE_LO_POS = 0;
	localparam int WAVE_HI_POS = 3;
	localparam logic [7:0] ACTION_CTRL_MASK = 8'hf3;
	localparam logic [7:0] MODE_CTRL_MASK = 8'h18;
	localparam logic [7:0] ACTION_CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [15:0] WIDE_RESET = 16'h0000;
	// ==================================================
	// output action codes
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW = 2'h2;
	localparam logic [1:0] ACT_HIGH = 2'h3;
	typedef enum logic [1:0] {WAVE_NONPWM, WAVE_FAST, WAVE_DUAL} wave_class_type;
endpackage

// >>> src/wide_reg_if.sv
`timescale 1ns/1ps
// write port of the wide register bank
interface wide_reg_if;
	logic [1:0] wr_sel;
	logic wr_en;
	logic [15:0] wr_data;
	logic [15:0] count;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic [15:0] capt;
	modport ctrl (output wr_sel, output wr_en, output wr_data, input count, input cmp_a, input cmp_b, input capt);
	modport bank (input wr_sel, input wr_en, input wr_data, output count, output cmp_a, output cmp_b, output capt);
endinterface

// >>> src/wide_reg_bank.sv
`timescale 1ns/1ps
// four 16-bit registers, each loaded whole in one cycle
module wide_reg_bank
	import timer16_pkg::*;
(
	input wire logic clk, // io clock
	input wire logic rst, // async reset
	input wire logic ce, // clock enable
	input wire logic [15:0] count_in, // running count from counter
	input wire logic count_upd, // counter advances count
	input wire logic [15:0] capt_in, // captured count
	input wire logic capt_upd, // capture event
	wide_reg_if.bank wr // write port
);
	logic [15:0] regs_q [4];
	logic [15:0] regs_d [4];

	// ==================================================
	// next values: cpu write wins over the timer's own update
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (count_upd) begin
			regs_d[0] = count_in;
		end
		if (capt_upd) begin
			regs_d[3] = capt_in;
		end
		if (wr.wr_en) begin
			regs_d[wr.wr_sel] = wr.wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				regs_q[i] <= WIDE_RESET;
			end
		end else if (ce) begin
			regs_q <= regs_d;
		end
	end

	assign wr.count = regs_q[0];
	assign wr.cmp_a = regs_q[1];
	assign wr.cmp_b = regs_q[2];
	assign wr.capt = regs_q[3];
endmodule

// >>> src/timer16_access.sv
// Operation
// - wide registers reached as two byte transfers
// - one shared high-byte latch per timer
// - low-byte write loads latch plus byte
// - low-byte read copies high half to latch
// - compare reads bypass latch, latch unchanged
// - latch survives low-byte write for reuse
// - nonzero action field overrides port pin
// - pin driver needs direction bit set
// - non-pwm codes: off, toggle, low, high
// - pwm code one: toggle a if top bit
// - fast pwm codes two/three clear/set schemes
// - fast pwm ignores match at top
// - dual-slope codes follow count direction
// - action decoded by four-bit waveform mode
// - waveform mode split across two controls
`timescale 1ns/1ps
module timer16_access
	import timer16_pkg::*;
(
	input wire logic clk, // io clock, 200 MHz
	input wire logic rst, // async reset, active high
	input wire logic ce, // clock enable, freezes state
	input wire logic [3:0] addr, // register index
	input wire logic wr_en, // byte write strobe
	input wire logic rd_en, // byte read strobe
	input wire logic [7:0] wdata, // write byte
	output logic [7:0] rdata, // read byte, registered
	input wire logic [15:0] count_in, // counter's next count
	input wire logic count_upd, // counter advances
	input wire logic [15:0] capt_in, // captured count
	input wire logic capt_upd, // capture event
	input wire logic match_a, // compare match channel a
	input wire logic match_b, // compare match channel b
	input wire logic at_bottom, // counter at bottom
	input wire logic at_top, // counter at top
	input wire logic count_down, // dual slope counting down
	input wire logic dir_a, // port direction for pin a
	input wire logic dir_b, // port direction for pin b
	output logic compare_out_a, // pin a level
	output logic compare_out_b, // pin b level
	output logic override_a, // pin a taken from port
	output logic override_b, // pin b taken from port
	output logic drive_a, // pin a driver enable
	output logic drive_b, // pin b driver enable
	output logic [3:0] waveform_select // mode to counter
);
	wide_reg_if wri ();
	logic [7:0] latch_q, latch_d;
	logic [7:0] action_q, action_d;
	logic [7:0] mode_q, mode_d;
	logic [7:0] rdata_d;
	logic [3:0] wave;
	wave_class_type wclass;
	logic [1:0] act [2];
	logic [1:0] pin_q, pin_d;
	logic [1:0] ovr_d, ovr_q, drv_d, drv_q;
	logic [1:0] match;
	logic [1:0] cmp_at_top;
	logic [1:0] dir;

	wide_reg_bank bank_i (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.count_in(count_in),
		.count_upd(count_upd),
		.capt_in(capt_in),
		.capt_upd(capt_upd),
		.wr(wri)
	);

	// ==================================================
	// cpu byte access
	// mode split over two
	assign wave = {mode_q[WAVE_HI_POS+1], mode_q[WAVE_HI_POS], action_q[WAVE_LO_POS+1], action_q[WAVE_LO_POS]};

	// low-byte writes commit a whole word; high-byte writes only touch the latch
	always_comb begin
		latch_d = latch_q;
		action_d = action_q;
		mode_d = mode_q;
		wri.wr_en = 1'b0;
		wri.wr_sel = 2'h0;
		wri.wr_data = {latch_q, wdata};
		rdata_d = rdata;
		if (wr_en) begin
			unique case (addr)
				ADDR_ACTION_CTRL: action_d = wdata & ACTION_CTRL_MASK;
				ADDR_MODE_CTRL: mode_d = wdata & MODE_CTRL_MASK;
				ADDR_COUNT_LO, ADDR_CMPA_LO, ADDR_CMPB_LO, ADDR_CAPT_LO: begin
					wri.wr_en = 1'b1;
					wri.wr_sel = addr[2:1] - 2'h1;
				end
				ADDR_COUNT_HI, ADDR_CMPA_HI, ADDR_CMPB_HI, ADDR_CAPT_HI: latch_d = wdata;
				default: ;
			endcase
		end else if (rd_en) begin
			unique case (addr)
				ADDR_ACTION_CTRL: rdata_d = action_q;
				ADDR_MODE_CTRL: rdata_d = mode_q;
				ADDR_COUNT_LO: begin
					rdata_d = wri.count[7:0];
					latch_d = wri.count[15:8];
				end
				ADDR_CAPT_LO: begin
					rdata_d = wri.capt[7:0];
					latch_d = wri.capt[15:8];
				end
				ADDR_CMPA_LO: rdata_d = wri.cmp_a[7:0];
				ADDR_CMPA_HI: rdata_d = wri.cmp_a[15:8];
				ADDR_CMPB_LO: rdata_d = wri.cmp_b[7:0];
				ADDR_CMPB_HI: rdata_d = wri.cmp_b[15:8];
				ADDR_COUNT_HI, ADDR_CAPT_HI: rdata_d = latch_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_q <= LATCH_RESET;
			action_q <= ACTION_CTRL_RESET;
			mode_q <= MODE_CTRL_RESET;
			rdata <= 8'h00;
		end else if (ce) begin
			latch_q <= latch_d;
			action_q <= action_d;
			mode_q <= mode_d;
			rdata <= rdata_d;
		end
	end

	// ==================================================
	// waveform class and compare output logic
	// classify four-bit mode
	always_comb begin
		unique case (wave)
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: wclass = WAVE_FAST;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: wclass = WAVE_DUAL;
			default: wclass = WAVE_NONPWM;
		endcase
	end

	// top value per mode; fixed tops plus the register sources
	function automatic logic [15:0] top_of(input logic [3:0] w, input logic [15:0] ca, input logic [15:0] cp);
		unique case (w)
			4'h1, 4'h5: top_of = 16'h00ff;
			4'h2, 4'h6: top_of = 16'h01ff;
			4'h3, 4'h7: top_of = 16'h03ff;
			4'h9, 4'hb, 4'hf, 4'h4: top_of = ca;
			4'h8, 4'ha, 4'he, 4'hc: top_of = cp;
			default: top_of = 16'hffff;
		endcase
	endfunction

	assign act[0] = action_q[ACTION_A_POS +: 2];
	assign act[1] = action_q[ACTION_B_POS +: 2];
	assign match = {match_b, match_a};
	assign dir = {dir_b, dir_a};
	assign cmp_at_top[0] = (wri.cmp_a == top_of(wave, wri.cmp_a, wri.capt));
	assign cmp_at_top[1] = (wri.cmp_b == top_of(wave, wri.cmp_a, wri.capt));

	// per channel: pin level, override and driver enable
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pin_d[c] = pin_q[c];
			ovr_d[c] = (act[c] != ACT_OFF);
			// code one disconnects unless top bit, and only channel a
			if (wclass != WAVE_NONPWM && act[c] == ACT_TOGGLE && !(wave[3] && c == 0)) begin
				ovr_d[c] = 1'b0;
			end
			drv_d[c] = ovr_d[c] & dir[c];
			unique case (wclass)
				WAVE_NONPWM: begin
					if (match[c]) begin
						unique case (act[c])
							ACT_TOGGLE: pin_d[c] = ~pin_q[c];
							ACT_LOW: pin_d[c] = 1'b0;
							ACT_HIGH: pin_d[c] = 1'b1;
							default: ;
						endcase
					end
				end
				WAVE_FAST: begin
					if (act[c][1] && at_bottom) begin
						pin_d[c] = ~act[c][0];
					end
					if (match[c] && act[c][1] && !(cmp_at_top[c] && at_top)) begin
						pin_d[c] = act[c][0];
					end
					if (match[c] && ovr_d[c] && act[c] == ACT_TOGGLE) begin
						pin_d[c] = ~pin_q[c];
					end
				end
				WAVE_DUAL: begin
					if (match[c] && act[c][1]) begin
						pin_d[c] = act[c][0] ^ count_down;
					end
					if (match[c] && ovr_d[c] && act[c] == ACT_TOGGLE) begin
						pin_d[c] = ~pin_q[c];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_q <= 2'h0;
			ovr_q <= 2'h0;
			drv_q <= 2'h0;
			waveform_select <= 4'h0;
		end else if (ce) begin
			pin_q <= pin_d;
			ovr_q <= ovr_d;
			drv_q <= drv_d;
			waveform_select <= wave;
		end
	end

	assign compare_out_a = pin_q[0];
	assign compare_out_b = pin_q[1];
	assign override_a = ovr_q[0];
	assign override_b = ovr_q[1];
	assign drive_a = drv_q[0];
	assign drive_b = drv_q[1];
endmodule

// >>> verif/timer16_access_props.sv
`timescale 1ns/1ps
module timer16_access_chk
	import timer16_pkg::*;
(
	input wire logic clk, // io clock
	input wire logic rst, // reset
	input wire logic ce, // enable
	input wire logic [3:0] addr, // index
	input wire logic wr_en, // write
	input wire logic [7:0] wdata, // byte
	input wire logic match_a, // match
	input wire logic at_bottom, // bottom
	input wire logic at_top, // top
	input wire logic count_down, // slope
	input wire logic dir_a, // pin a direction
	input wire logic compare_out_a, // pin
	input wire logic override_a, // override
	input wire logic drive_a, // driver
	input wire logic [3:0] waveform_select // mode
);
	logic [7:0] act_q;
	logic [7:0] act_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [3:0] wave;
	logic [1:0] ca;
	logic m;
	logic np;
	logic fast;
	logic dual;
	logic ovr_exp;
	// shadows of both control registers; they move only on a taken write
	assign act_d = (ce && wr_en && addr == ADDR_ACTION_CTRL) ? (wdata & ACTION_CTRL_MASK) : act_q;
	assign mode_d = (ce && wr_en && addr == ADDR_MODE_CTRL) ? (wdata & MODE_CTRL_MASK) : mode_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			act_q <= ACTION_CTRL_RESET;
			mode_q <= MODE_CTRL_RESET;
		end else begin
			act_q <= act_d;
			mode_q <= mode_d;
		end
	end
	// the mode as the pin logic sees it; the waveform_select output lags it by a cycle
	assign wave = {mode_q[WAVE_HI_POS +: 2], act_q[WAVE_LO_POS +: 2]};
	// mode class and taken match; frozen cycles prove nothing
	assign ca = act_q[ACTION_A_POS +: 2];
	assign m = ce && match_a;
	assign fast = wave inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
	assign dual = wave inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
	assign np = !fast && !dual;
	// code one in a pwm mode keeps pin a only while the top mode bit is set
	assign ovr_exp = (ca != ACT_OFF) && !(!np && ca == ACT_TOGGLE && !wave[3]);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==================================================
	// channel a pin behaviour
	ovr_follow_a: assert property ($past(ce) |-> override_a == $past(ovr_exp))
		else $error("override wrong");
	drive_gate_a: assert property ($past(ce) |-> drive_a == (override_a && $past(dir_a)))
		else $error("driver enable wrong");
	toggle_match_a: assert property (m && np && ca == ACT_TOGGLE |=> compare_out_a != $past(compare_out_a))
		else $error("no toggle");
	level_match_a: assert property (m && np && ca[1] |=> compare_out_a == $past(ca[0]))
		else $error("wrong level on match");
	fast_bottom_a: assert property (ce && at_bottom && !match_a && fast && ca[1] |=> compare_out_a == !$past(ca[0]))
		else $error("wrong level at bottom");
	// in mode fifteen compare a is the top itself, so a match at top is always the special case
	fast_top_a: assert property (m && at_top && !at_bottom && wave == 4'hf && ca[1] |=> $stable(compare_out_a))
		else $error("match at top not ignored");
	dual_match_a: assert property (m && dual && ca[1] |=> compare_out_a == ($past(ca[0]) ^ $past(count_down)))
		else $error("wrong dual slope level");
	mode_low_a: assert property ($past(ce) |-> waveform_select == $past(wave))
		else $error("mode output wrong");
	cover property (m && fast && at_top);
	cover property (m && dual && count_down);
	cover property (ce && at_bottom && fast);
endmodule
bind timer16_access timer16_access_chk chk_u (
	.clk(clk),
	.rst(rst),
	.ce(ce),
	.addr(addr),
	.wr_en(wr_en),
	.wdata(wdata),
	.match_a(match_a),
	.at_bottom(at_bottom),
	.at_top(at_top),
	.count_down(count_down),
	.dir_a(dir_a),
	.compare_out_a(compare_out_a),
	.override_a(override_a),
	.drive_a(drive_a),
	.waveform_select(waveform_select)
);

// >>> verif/cpu_bus_model.sv
`timescale 1ns/1ps
// byte-wide cpu on the register port
module cpu_bus_model
	import timer16_pkg::*;
(
	input wire logic clk, // io clock
	output logic [3:0] addr, // index
	output logic wr_en, // write
	output logic rd_en, // read
	output logic [7:0] wdata, // byte out
	input wire logic [7:0] rdata // byte in
);
	initial begin
		addr = 4'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
	end
	// one transfer, launched and released on falling edges; released data shows the inverse
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = wr;
		rd_en = !wr;
		@(negedge clk);
		q = rdata;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = ~d;
	endtask
	// high byte first, pair never split
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		logic [7:0] q;
		xfer(1'b1, lo + 4'h1, v[15:8], q);
		xfer(1'b1, lo, v[7:0], q);
	endtask
	// low byte first, pair never split
	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		xfer(1'b0, lo, 8'h00, v[7:0]);
		xfer(1'b0, lo + 4'h1, 8'h00, v[15:8]);
	endtask
endmodule

// >>> verif/tb_timer16_access.sv
`timescale 1ns/1ps
module tb_timer16_access
	import timer16_pkg::*;
;
	logic clk, rst, ce, wr_en, rd_en, count_upd, capt_upd, match_a, match_b, at_bottom, at_top, count_down;
	logic dir_a, dir_b, compare_out_a, compare_out_b, override_a, override_b, drive_a, drive_b;
	logic [3:0] addr, waveform_select;
	logic [7:0] wdata, rdata, q;
	logic [15:0] count_in, capt_in, v;
	logic [15:0] rows [16];
	int num_errors = 0;
	int n_compared = 0;
	timer16_access dut_u (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.addr(addr),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.wdata(wdata),
		.rdata(rdata),
		.count_in(count_in),
		.count_upd(count_upd),
		.capt_in(capt_in),
		.capt_upd(capt_upd),
		.match_a(match_a),
		.match_b(match_b),
		.at_bottom(at_bottom),
		.at_top(at_top),
		.count_down(count_down),
		.dir_a(dir_a),
		.dir_b(dir_b),
		.compare_out_a(compare_out_a),
		.compare_out_b(compare_out_b),
		.override_a(override_a),
		.override_b(override_b),
		.drive_a(drive_a),
		.drive_b(drive_b),
		.waveform_select(waveform_select)
	);
	cpu_bus_model cpu_u (
		.clk(clk),
		.addr(addr),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.wdata(wdata),
		.rdata(rdata)
	);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ==================================================
	// rows: pin b, override b, two spare, mode, action code, match, bottom, top, down, pin a, override a
	initial begin
		rows = '{16'hc063, 16'h4061, 16'hc4e3, 16'h4ca1, 16'hc593, 16'h45a1, 16'h45d1, 16'hc5e3,
			16'hcfab, 16'h41a1, 16'hc1a7, 16'hcae3, 16'h48e5, 16'h0f63, 16'h0762, 16'h0e61};
		{ce, count_upd, capt_upd, match_a, match_b, at_bottom, at_top, count_down, dir_b, dir_a} = 10'h201;
		count_in = 16'h0000;
		capt_in = 16'h0000;
		rst = 1'b1;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		// each row rewrites both controls; the pin carries over between rows
		for (int i = 0; i < 16; i++) begin
			cpu_u.xfer(1'b1, ADDR_MODE_CTRL, {3'h0, rows[i][11:10], 3'h0}, q);
			cpu_u.xfer(1'b1, ADDR_ACTION_CTRL, {rows[i][7:6], rows[i][7:6], 2'h0, rows[i][9:8]}, q);
			{match_a, at_bottom, at_top, count_down} = rows[i][5:2];
			match_b = match_a;
			@(negedge clk);
			{match_a, match_b, at_bottom, at_top} = 4'h0;
			@(negedge clk);
			check(compare_out_a, rows[i][1]);
			check(override_a, rows[i][0]);
			check(compare_out_b, rows[i][15]);
			check(override_b, rows[i][14]);
			check(waveform_select, rows[i][11:8]);
		end
		// driver enable follows the direction bit
		dir_a = 1'b0;
		repeat (2) @(negedge clk);
		check(drive_a, 1'b0);
		dir_a = 1'b1;
		repeat (2) @(negedge clk);
		check(drive_a, 1'b1);
		// channel b: direction alone does not drive, the action field must connect it too
		dir_b = 1'b1;
		repeat (2) @(negedge clk);
		check(drive_b, 1'b0);
		cpu_u.xfer(1'b1, ADDR_ACTION_CTRL, 8'h20, q);
		repeat (2) @(negedge clk);
		check(override_a, 1'b0);
		check(drive_a, 1'b0);
		check(override_b, 1'b1);
		check(drive_b, 1'b1);
		// a frozen clock enable drops the write; readback shows only the implemented bits
		ce = 1'b0;
		cpu_u.xfer(1'b1, ADDR_ACTION_CTRL, 8'h5c, q);
		ce = 1'b1;
		cpu_u.xfer(1'b0, ADDR_ACTION_CTRL, 8'h00, q);
		check(q, 8'h20);
		cpu_u.xfer(1'b1, ADDR_ACTION_CTRL, 8'hff, q);
		cpu_u.xfer(1'b0, ADDR_ACTION_CTRL, 8'h00, q);
		check(q, ACTION_CTRL_MASK);
		cpu_u.xfer(1'b0, ADDR_MODE_CTRL, 8'h00, q);
		check(q, 8'h18);
		// one high byte shared by two compare writes
		cpu_u.wr16(ADDR_CMPA_LO, 16'h5a11);
		cpu_u.xfer(1'b1, ADDR_CMPB_LO, 8'h22, q);
		cpu_u.wr16(ADDR_COUNT_LO, 16'h01ff);
		cpu_u.rd16(ADDR_COUNT_LO, v);
		check(v, 16'h01ff);
		cpu_u.rd16(ADDR_CMPB_LO, v);
		check(v, 16'h5a22);
		// count moves mid-pair; a compare read must not disturb the latch
		cpu_u.xfer(1'b0, ADDR_COUNT_LO, 8'h00, q);
		check(q, 8'hff);
		count_in = 16'h7777;
		count_upd = 1'b1;
		@(negedge clk);
		count_upd = 1'b0;
		cpu_u.xfer(1'b0, ADDR_CMPA_HI, 8'h00, q);
		check(q, 8'h5a);
		cpu_u.xfer(1'b0, ADDR_COUNT_HI, 8'h00, q);
		check(q, 8'h01);
		cpu_u.rd16(ADDR_COUNT_LO, v);
		check(v, 16'h7777);
		// capture snapshot read through the latch, then a cpu write of the capture register
		capt_in = 16'h3c4d;
		capt_upd = 1'b1;
		@(negedge clk);
		capt_upd = 1'b0;
		cpu_u.rd16(ADDR_CAPT_LO, v);
		check(v, 16'h3c4d);
		cpu_u.wr16(ADDR_CAPT_LO, 16'h1234);
		cpu_u.rd16(ADDR_CAPT_LO, v);
		check(v, 16'h1234);
		// unmapped index: write dropped, read gives zero
		cpu_u.xfer(1'b1, 4'hf, 8'h5a, q);
		cpu_u.xfer(1'b0, 4'hf, 8'h00, q);
		check(q, 8'h00);
		// second reset clears the latch and both fields
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		check(override_a, 1'b0);
		check(override_b, 1'b0);
		check(drive_b, 1'b0);
		check(waveform_select, 4'h0);
		cpu_u.xfer(1'b1, ADDR_COUNT_LO, 8'h33, q);
		cpu_u.rd16(ADDR_COUNT_LO, v);
		check(v, 16'h0033);
		conclude();
	end
endmodule
